// ---- pio_cfg.svh ----
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define PIO_IDX_A_DATA 4'h0
`define PIO_IDX_B_DATA 4'h1
`define PIO_IDX_A_DIR 4'h4
`define PIO_IDX_B_DIR 4'h5

// Port widths.
`define PIO_A_WIDTH 8
`define PIO_B_WIDTH 6

// Field positions.
`define PIO_B_CLKOUT_BIT 7
`define PIO_B_CLK_PIN 0
`define PIO_KBD_LO 1
`define PIO_KBD_HI 6

// Reset values and masks.
`define PIO_DIR_RESET 8'h00
`define PIO_A_KBD_MASK 8'h7e
`define PIO_B_DATA_MASK 8'h3f
`define PIO_B_DIR_MASK 8'hbf
`define PIO_ZERO_WORD 32'h0000_0000

`endif

// ---- pio_pkg.sv ----
package pio_pkg;

    // Drive of one group of pins toward the pads.
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] drive_en;
        logic [7:0] pullup_en;
    } pio_pad_drive_t;

    // APB request as seen on the bus inputs in every cycle, setup and access phase alike.
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } pio_apb_req_t;

    // Registered APB answer.
    typedef struct packed {
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } pio_apb_rsp_t;

endpackage : pio_pkg

// ---- pio_sync.sv ----
`timescale 1ns/100ps
`default_nettype none

module pio_sync #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync_out;

    // The first stage feeds only the second stage.
    always_comb begin
        next_meta = rst ? '0 : async_in;
        next_sync_out = rst ? '0 : meta;
    end

    always_ff @(posedge clk_sys) begin
        meta <= next_meta;
        sync_out <= next_sync_out;
    end

endmodule : pio_sync

`default_nettype wire

// ---- pio_ports.sv ----
// Notes on behaviour
// (R01) Port A data register at index 0 holds eight output latches.
// (R02) Reset leaves port A data latches unchanged.
// (R03) Port A direction bit 1 enables the pin driver, 0 disables it.
// (R04) Reset clears all port A direction bits; pins start as inputs.
// (R05) Port A data read returns the latch where direction is 1.
// (R06) Port A data read returns the pin level where direction is 0.
// (R07) Latch writes always land; input pins read back unaffected.
// (R08) Keypad enable forces the pin to input and switches on its pullup.
// (R09) Keypad pins read the pin only when direction is 0.
// (R10) Only port A bits 6 to 1 have the keypad function.
// (R11) Pullup is on only while the pin is keypad-enabled.
// (R12) Port B data has latches in bits 5..0, untouched by reset.
// (R13) Port B direction: clock-out enable bit 7, bits 5..0, reset 0.
// (R14) Software should load the latch before turning a pin to output.
// (R15) Clock-out enable drives the bus clock onto port B pin 0; the code drives clk_sys divided by two there.
// (R16) Port B data read: latch where direction is 1, else pin.
// (R17) Unimplemented bits read zero and ignore writes.
//
// Our own choice: register access over APB.
`include "pio_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module pio_ports #(
    parameter int A_W = `PIO_A_WIDTH,
    parameter int B_W = `PIO_B_WIDTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] keypad_irq_enable,
    input wire logic [7:0] first_port_pin_in,
    output logic [7:0] first_port_pin_out,
    output logic [7:0] first_port_pin_oe,
    output logic [7:0] first_port_pullup,
    input wire logic [5:0] second_port_pin_in,
    output logic [5:0] second_port_pin_out,
    output logic [5:0] second_port_pin_oe
);

    function automatic logic [7:0] byte_addr(input logic [3:0] idx);
        byte_addr = {2'b00, idx, 2'b00};
    endfunction : byte_addr

    // Per bit: latch where the direction bit is 1, synchronised pin otherwise.
    function automatic logic [7:0] mix_read(input logic [7:0] dir,
                                             input logic [7:0] latch,
                                             input logic [7:0] pin);
        mix_read = (dir & latch) | (~dir & pin);
    endfunction : mix_read

    pio_pkg::pio_apb_req_t req;
    pio_pkg::pio_apb_rsp_t rsp;
    pio_pkg::pio_apb_rsp_t next_rsp;
    pio_pkg::pio_pad_drive_t pad_a;
    pio_pkg::pio_pad_drive_t next_pad_a;

    logic [7:0] first_port_latch;
    logic [7:0] next_first_port_latch;
    logic [7:0] second_port_latch;
    logic [7:0] next_second_port_latch;
    logic [7:0] first_port_direction;
    logic [7:0] next_first_port_direction;
    logic [7:0] second_port_direction;
    logic [7:0] next_second_port_direction;
    logic bus_clock_image;
    logic next_bus_clock_image;
    logic [5:0] pin_b_out;
    logic [5:0] next_pin_b_out;
    logic [5:0] pin_b_oe;
    logic [5:0] next_pin_b_oe;

    logic [7:0] pin_a_sync;
    logic [5:0] pin_b_sync;
    logic [7:0] kbd_en;
    logic bus_write;
    logic [7:0] rd_byte;
    logic hit;

    assign req = '{sel: psel, enable: penable, write: pwrite,
                   addr: paddr, wdata: pwdata};

    pio_sync #(.W(A_W)) u_sync_a (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(first_port_pin_in),
        .sync_out(pin_a_sync)
    );

    pio_sync #(.W(B_W)) u_sync_b (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(second_port_pin_in),
        .sync_out(pin_b_sync)
    );

    // (R10) Keypad bits mapped
    // Only bits 6..1 carry the keypad function; bits 7 and 0 never do.
    always_comb begin
        kbd_en = {1'b0, keypad_irq_enable, 1'b0} & `PIO_A_KBD_MASK;
    end

    // A write takes effect at the edge that completes the access phase.
    always_comb begin
        bus_write = req.sel & req.enable & rsp.ready & req.write;
    end

    // Read decode and address check for the setup cycle.
    always_comb begin
        rd_byte = 8'h00;
        hit = 1'b1;
        unique case (req.addr)
            byte_addr(`PIO_IDX_A_DATA): begin
                // (R05) Output bits read latch
                // (R06) Input bits read pin
                // (R09) Keypad pins follow direction
                rd_byte = mix_read(first_port_direction, first_port_latch,
                                   pin_a_sync);
            end
            byte_addr(`PIO_IDX_B_DATA): begin
                // (R16) Port B mixed read
                // (R17) Upper bits zero
                rd_byte = mix_read(second_port_direction, second_port_latch,
                                   {2'b00, pin_b_sync})
                          & `PIO_B_DATA_MASK;
            end
            byte_addr(`PIO_IDX_A_DIR): begin
                rd_byte = first_port_direction;
            end
            byte_addr(`PIO_IDX_B_DIR): begin
                rd_byte = second_port_direction;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Answer group: one wait-free access phase, error on unmapped address.
    always_comb begin
        next_rsp = rsp;
        if (rst) begin
            next_rsp = '{ready: 1'b0, slverr: 1'b0, rdata: `PIO_ZERO_WORD};
        end else if (req.sel & ~req.enable & ~rsp.ready) begin
            next_rsp.ready = 1'b1;
            next_rsp.slverr = ~hit;
            next_rsp.rdata = req.write ? `PIO_ZERO_WORD
                                       : {24'h00_0000, rd_byte};
        end else begin
            next_rsp.ready = 1'b0;
            next_rsp.slverr = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        rsp <= next_rsp;
    end

    assign prdata = rsp.rdata;
    assign pready = rsp.ready;
    assign pslverr = rsp.slverr;

    // Data latches carry no reset term at all.
    always_comb begin
        next_first_port_latch = first_port_latch;
        next_second_port_latch = second_port_latch;
        // (R01) Port A latch write
        // (R07) Write regardless of direction
        if (bus_write && req.addr == byte_addr(`PIO_IDX_A_DATA)) begin
            next_first_port_latch = req.wdata[7:0];
        end
        // (R12) Six port B latches
        // (R17) Dead bits ignore writes
        if (bus_write && req.addr == byte_addr(`PIO_IDX_B_DATA)) begin
            next_second_port_latch = req.wdata[7:0] & `PIO_B_DATA_MASK;
        end
    end

    // (R02) No reset on latches
    always_ff @(posedge clk_sys) begin
        first_port_latch <= next_first_port_latch;
        second_port_latch <= next_second_port_latch;
    end

    // Direction registers.
    always_comb begin
        next_first_port_direction = first_port_direction;
        next_second_port_direction = second_port_direction;
        if (rst) begin
            // (R04) Port A all inputs
            // (R13) Port B cleared
            next_first_port_direction = `PIO_DIR_RESET;
            next_second_port_direction = `PIO_DIR_RESET;
        end else begin
            if (bus_write && req.addr == byte_addr(`PIO_IDX_A_DIR)) begin
                next_first_port_direction = req.wdata[7:0];
            end
            // (R13) Bit 6 unimplemented
            if (bus_write && req.addr == byte_addr(`PIO_IDX_B_DIR)) begin
                next_second_port_direction = req.wdata[7:0]
                                             & `PIO_B_DIR_MASK;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        first_port_direction <= next_first_port_direction;
        second_port_direction <= next_second_port_direction;
    end

    // Port A pad drive. The enable changes at the same edge as the direction write,
    // which keeps every pad signal straight off a flip-flop.
    always_comb begin
        next_pad_a.level = next_first_port_latch;
        if (rst) begin
            next_pad_a.drive_en = 8'h00;
            next_pad_a.pullup_en = 8'h00;
        end else begin
            // (R03) Direction enables driver
            // (R08) Keypad forces input
            next_pad_a.drive_en = next_first_port_direction & ~kbd_en;
            // (R11) Pullup only when keypad
            next_pad_a.pullup_en = kbd_en;
        end
    end

    always_ff @(posedge clk_sys) begin
        pad_a <= next_pad_a;
    end

    assign first_port_pin_out = pad_a.level;
    assign first_port_pin_oe = pad_a.drive_en;
    assign first_port_pullup = pad_a.pullup_en;

    // The bus clock image is a half-rate toggle; a true clock cannot leave
    // through a flip-flop, so the pad sees clk_sys divided by two.
    always_comb begin
        next_bus_clock_image = rst ? 1'b0 : ~bus_clock_image;
    end

    always_ff @(posedge clk_sys) begin
        bus_clock_image <= next_bus_clock_image;
    end

    // Port B pad drive.
    always_comb begin
        next_pin_b_out = next_second_port_latch[5:0];
        next_pin_b_oe = rst ? 6'h00 : next_second_port_direction[5:0];
        // (R15) Clock onto pin 0
        if (!rst && next_second_port_direction[`PIO_B_CLKOUT_BIT]) begin
            next_pin_b_out[`PIO_B_CLK_PIN] = next_bus_clock_image;
            next_pin_b_oe[`PIO_B_CLK_PIN] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        pin_b_out <= next_pin_b_out;
        pin_b_oe <= next_pin_b_oe;
    end

    assign second_port_pin_out = pin_b_out;
    assign second_port_pin_oe = pin_b_oe;

endmodule : pio_ports

`default_nettype wire

// ---- pio_ports_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module pio_ports_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] keypad_irq_enable,
    input wire logic [7:0] first_port_pin_out,
    input wire logic [7:0] first_port_pin_oe,
    input wire logic [7:0] first_port_pullup,
    input wire logic [5:0] second_port_pin_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic wr;
    logic [7:0] wbyte;
    assign wr = psel && penable && pready && pwrite;
    assign wbyte = pwdata[7:0];
    a_latch_pin: assert property (
        wr && paddr == 8'h00 |=> first_port_pin_out == $past(wbyte))
        else $error("pin out differs from latch");
    a_dir_drive: assert property (
        wr && paddr == 8'h10 |=>
        first_port_pin_oe == ($past(wbyte) & ~first_port_pullup))
        else $error("port A enable differs");
    a_b_dir: assert property (
        wr && paddr == 8'h14 |=>
        {2'b00, second_port_pin_oe[5:1], 1'b0} == ($past(wbyte) & 8'h3e))
        else $error("port B enable differs");
    a_clk_out: assert property (
        wr && paddr == 8'h14 && wbyte[7] |=> second_port_pin_oe[0])
        else $error("clock pin not driven");
    a_ready_once: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("ready timing wrong");
    a_err_zero: assert property (
        pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error answer not clean");
    a_upper_zero: assert property (
        pready |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_keypad_in: assert property (
        (first_port_pullup & first_port_pin_oe) == 8'h00)
        else $error("keypad pin driven");
    a_pull_range: assert property (
        (first_port_pullup & 8'h81) == 8'h00)
        else $error("pullup on plain pin");
    a_pull_follow: assert property (
        !$past(rst) |->
        first_port_pullup[6:1] == $past(keypad_irq_enable))
        else $error("pullup does not follow enable");
    c_clk_out: cover property (wr && paddr == 8'h14 && wbyte[7]);
    c_refused: cover property (pslverr);
    c_pullup: cover property (first_port_pullup != 8'h00);
endmodule : pio_ports_assertions
bind pio_ports pio_ports_assertions pio_ports_assertions_i (.*);
`default_nettype wire

// ---- pio_pad_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pio_pad_model (
    input wire logic clk_sys,
    input wire logic [7:0] first_port_pin_out,
    input wire logic [7:0] first_port_pin_oe,
    input wire logic [7:0] first_port_pullup,
    input wire logic [5:0] second_port_pin_out,
    input wire logic [5:0] second_port_pin_oe,
    input wire logic [7:0] ext_a,
    input wire logic [7:0] ext_a_en,
    input wire logic [5:0] ext_b,
    output logic [7:0] first_port_pin_in,
    output logic [5:0] second_port_pin_in
);
    // A pin that nobody holds wanders, so it never reads as a level.
    logic wander = 1'b0;
    always @(posedge clk_sys) wander <= ~wander;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (first_port_pin_oe[i])
                first_port_pin_in[i] = first_port_pin_out[i];
            else if (ext_a_en[i]) first_port_pin_in[i] = ext_a[i];
            else if (first_port_pullup[i]) first_port_pin_in[i] = 1'b1;
            else first_port_pin_in[i] = wander;
        end
    end
    assign second_port_pin_in = (second_port_pin_oe & second_port_pin_out)
        | (~second_port_pin_oe & ext_b);
endmodule : pio_pad_model
`default_nettype wire

// ---- parallel_io_ports_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module parallel_io_ports_bench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, er, cv;
    logic [7:0] paddr, ext_a, ext_a_en;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] keypad_irq_enable, ext_b;
    logic [7:0] first_port_pin_in, first_port_pin_out;
    logic [7:0] first_port_pin_oe, first_port_pullup;
    logic [5:0] second_port_pin_in, second_port_pin_out, second_port_pin_oe;
    int mismatches = 0;
    int num_checks = 0;
    always #5 clk_sys = ~clk_sys;
    pio_ports pio_ports_i (.*);
    pio_pad_model pio_pad_model_i (.*);
    task automatic complete_run;
        if (mismatches == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pin(input logic [7:0] got, input logic [7:0] exp);
        chk({24'h00_0000, got}, {24'h00_0000, exp});
    endtask : pin
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rd, {24'h00_0000, exp});
    endtask : rdchk
    initial begin
        #20000;
        mismatches++;
        complete_run();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        keypad_irq_enable = 6'h00;
        ext_a = 8'h3c;
        ext_a_en = 8'hff;
        ext_b = 6'h2a;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk(8'h10, 8'h00);
        rdchk(8'h14, 8'h00);
        pin(first_port_pin_oe, 8'h00);
        pin(first_port_pullup, 8'h00);
        bus(1'b1, 8'h00, 8'ha5);
        bus(1'b1, 8'h10, 8'hf0);
        @(negedge clk_sys);
        pin(first_port_pin_oe, 8'hf0);
        rdchk(8'h00, 8'hac);
        bus(1'b1, 8'h00, 8'h5a);
        rdchk(8'h00, 8'h5c);
        pin(first_port_pin_out, 8'h5a);
        bus(1'b1, 8'h10, 8'h00);
        ext_a_en <= 8'h81;
        keypad_irq_enable <= 6'h3f;
        repeat (4) @(posedge clk_sys);
        rdchk(8'h00, 8'h7e);
        pin(first_port_pullup, 8'h7e);
        bus(1'b1, 8'h10, 8'hff);
        @(negedge clk_sys);
        pin(first_port_pin_oe, 8'h81);
        rdchk(8'h00, 8'h5a);
        keypad_irq_enable <= 6'h00;
        bus(1'b1, 8'h04, 8'hff);
        bus(1'b1, 8'h14, 8'h3f);
        rdchk(8'h04, 8'h3f);
        pin({2'b00, second_port_pin_out}, 8'h3f);
        bus(1'b1, 8'h14, 8'hff);
        rdchk(8'h14, 8'hbf);
        @(negedge clk_sys);
        pin({2'b00, second_port_pin_oe}, 8'h3f);
        cv = second_port_pin_out[0];
        @(negedge clk_sys);
        pin({7'h00, second_port_pin_out[0]}, {7'h00, ~cv});
        bus(1'b1, 8'h14, 8'h00);
        repeat (2) @(posedge clk_sys);
        rdchk(8'h04, 8'h2a);
        bus(1'b1, 8'h11, 8'h00);
        pin({7'h00, er}, 8'h01);
        rdchk(8'h10, 8'hff);
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rdchk(8'h10, 8'h00);
        bus(1'b1, 8'h10, 8'hff);
        rdchk(8'h00, 8'h5a);
        bus(1'b1, 8'h14, 8'h3f);
        rdchk(8'h04, 8'h3f);
        complete_run();
    end
endmodule : parallel_io_ports_bench
`default_nettype wire
